// [pkg/ahp_map.svh]
// Purpose: Timing counts and widths shared by both ends of the converter host port
// Assumes: sys_clk at 10 MHz (100 ns period)
// Notes:   Counts derive from the printed times; least times round up
`ifndef AHP_MAP_SVH
`define AHP_MAP_SVH
`define AHP_CLK_PERIOD_NS   100
`define AHP_CONV_WAIT_NS    6500
`define AHP_CONV_WAIT_CYC   ((`AHP_CONV_WAIT_NS + `AHP_CLK_PERIOD_NS - 1) / `AHP_CLK_PERIOD_NS)
`define AHP_ACCESS_NS       57
`define AHP_ACCESS_CYC      ((`AHP_ACCESS_NS + `AHP_CLK_PERIOD_NS - 1) / `AHP_CLK_PERIOD_NS)
`define AHP_RD_WAIT_CYC     2
`define AHP_DATA_W          16
`define AHP_BYTE_W          8
`define AHP_FIFO_DEPTH      8
`endif

// [pkg/ahp_pkg.sv]
// Purpose: Types used by the host end and the bench; the converter end uses none of them
// Assumes: Included map header supplies widths
// Notes:   The one-hot state codes are the only numbers held here
`include "ahp_map.svh"
`default_nettype none
package ahp_pkg;
	typedef logic [`AHP_DATA_W-1:0] ahp_word_t;   // Full conversion result
	typedef logic [`AHP_BYTE_W-1:0] ahp_byte_t;   // One byte of result
	typedef enum logic [5:0]
	{
		AHP_H_IDLE  = 6'h01,                         // Waiting for a sample request
		AHP_H_START = 6'h02,                         // Start strobe low
		AHP_H_WAIT  = 6'h04,                         // Waiting for end of conversion
		AHP_H_READ  = 6'h08,                         // Select and read low
		AHP_H_GAP   = 6'h10,                         // Strobes high between bytes
		AHP_H_PUSH  = 6'h20                          // Result handed to the FIFO
	} ahp_host_state_t;
endpackage
`default_nettype wire

// [pkg/ahp_if.sv]
// Purpose: Pins between converter and host
// Assumes: Data bus is three-state; the interface resolves it
// Notes:   Floating bus reads as all ones here, modelling a pull-up
`include "ahp_map.svh"
`default_nettype none
interface ahp_if;
	logic                     conversion_start_n;  // Start strobe, low starts
	logic                     chip_select_n;       // Select, low active
	logic                     read_strobe_n;       // Read, low active
	logic                     byte_addr;           // Byte variant: 1 upper, 0 lower
	logic                     busy_n;              // Low during conversion
	logic [`AHP_DATA_W-1:0]   data_out;            // Converter's bus drive
	logic                     data_oe;             // High while converter drives
	logic [`AHP_DATA_W-1:0]   data_bus;            // Resolved bus level
	assign data_bus = data_oe ? data_out : {`AHP_DATA_W{1'b1}};
	modport adc
	(
		input  conversion_start_n, chip_select_n, read_strobe_n, byte_addr,
		output busy_n, data_out, data_oe
	);
	modport host
	(
		output conversion_start_n, chip_select_n, read_strobe_n, byte_addr,
		input  busy_n, data_bus
	);
endinterface
`default_nettype wire

// [design/ahp_fifo.sv]
// Purpose: Small synchronous FIFO carrying results to the host user side
// Assumes: One clock, synchronous active-low reset
// Notes:   Full and empty are exact; no write when full, no read when empty
`include "ahp_map.svh"
`default_nettype none
module ahp_fifo #(
	parameter int WIDTH = `AHP_DATA_W,
	parameter int DEPTH = `AHP_FIFO_DEPTH
)(
	input  wire logic             sys_clk,    // System clock
	input  wire logic             rst_b,      // Sync reset, low active
	input  wire logic [WIDTH-1:0] in_data,    // Write data
	input  wire logic             in_valid,   // Write request
	output logic                  in_ready,   // Not full
	output logic      [WIDTH-1:0] out_data,   // Head word
	output logic                  out_valid,  // Not empty
	input  wire logic             out_ready   // Consumer takes head
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];         // Storage
	logic [AW-1:0]    wr_ptr_reg;              // Write index
	logic [AW-1:0]    rd_ptr_reg;              // Read index
	logic [AW:0]      count_reg;               // Words held
	logic             do_wr;                   // Write this cycle
	logic             do_rd;                   // Read this cycle

	assign in_ready  = (count_reg != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
	assign out_valid = (count_reg != '0);
	assign do_wr     = in_valid && in_ready;
	assign do_rd     = out_valid && out_ready;
	assign out_data  = mem_reg[rd_ptr_reg];

	// Storage write; no reset needed for data
	always_ff @(posedge sys_clk)
	begin
		if (do_wr)
			mem_reg[wr_ptr_reg] <= in_data;
	end

	// Pointers wrap at DEPTH, which need not be a power of two
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end
		else
		begin
			if (do_wr)
				wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + AW'(1);
			if (do_rd)
				rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + AW'(1);
		end
	end

	// Occupancy
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
			count_reg <= '0;
		else if (do_wr && !do_rd)
			count_reg <= count_reg + (AW+1)'(1);
		else if (do_rd && !do_wr)
			count_reg <= count_reg - (AW+1)'(1);
	end
endmodule
`default_nettype wire

// [design/ahp_adc_end.sv]
// Purpose: Converter end: conversion timing, busy flag and three-state result bus
// Assumes: Start strobe and strobes are synchronous to sys_clk
// Notes:   Analog part replaced by the sample_value input taken at the start edge
`include "ahp_map.svh"
`default_nettype none
module ahp_adc_end #(
	parameter int CONV_CYC = `AHP_CONV_WAIT_CYC - 1,  // Conversion length in cycles
	parameter bit BYTE_WIDE = 1'b0                    // 1 selects the byte variant
)(
	input  wire logic               sys_clk,       // System clock
	input  wire logic               rst_b,         // Sync reset, low active
	input  wire logic [`AHP_DATA_W-1:0] sample_value, // Analog stand-in
	ahp_if.adc                      pins           // Pins to the host
);
	logic             start_d_reg;   // Start strobe last cycle
	logic             busy_n_reg;    // Busy pin
	logic [15:0]      cnt_reg;       // Conversion counter
	logic [`AHP_DATA_W-1:0] held_reg;  // Sample under conversion
	logic [`AHP_DATA_W-1:0] result_reg;// Finished result
	logic [`AHP_DATA_W-1:0] dout_reg;  // Bus drive
	logic             oe_reg;        // Bus enable
	logic             start_fall;    // Falling start edge

	assign start_fall = start_d_reg && !pins.conversion_start_n;

	// Edge memory for the start strobe
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
			start_d_reg <= 1'b1;
		else
			start_d_reg <= pins.conversion_start_n;
	end

	// Conversion: busy low throughout, high when result lands; starts mid-conversion are ignored
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			busy_n_reg <= 1'b1;
			cnt_reg    <= '0;
			held_reg   <= '0;
			result_reg <= '0;
		end
		else if (busy_n_reg && start_fall)
		begin
			busy_n_reg <= 1'b0;
			cnt_reg    <= 16'(CONV_CYC);
			held_reg   <= sample_value;
		end
		else if (!busy_n_reg)
		begin
			if (cnt_reg <= 16'h0001)
			begin
				busy_n_reg <= 1'b1;
				result_reg <= held_reg;         // Result and busy rise together
			end
			cnt_reg <= cnt_reg - 16'h0001;
		end
	end

	// Bus drive follows select and read both low, one cycle late
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			oe_reg   <= 1'b0;
			dout_reg <= '0;
		end
		else
		begin
			oe_reg <= !pins.chip_select_n && !pins.read_strobe_n;
			if (!BYTE_WIDE)
				dout_reg <= (!busy_n_reg && cnt_reg <= 16'h0001) ? held_reg : result_reg;
			else if (pins.byte_addr)
				dout_reg <= {8'h00, result_reg[15:8]};  // Odd address: upper byte
			else
				dout_reg <= {8'h00, result_reg[7:0]};   // Even address: lower byte
		end
	end

	assign pins.busy_n   = busy_n_reg;
	assign pins.data_oe  = oe_reg;
	assign pins.data_out = dout_reg;
endmodule
`default_nettype wire

// [design/ahp_host_end.sv]
// Purpose: Host end: starts conversions, waits on busy or on a timer, reads and queues results
// Assumes: One clock; all pins synchronous
// Notes:   Word or byte read chosen by BYTE_WIDE; results leave through an 8-word FIFO
`include "ahp_map.svh"
`default_nettype none
module ahp_host_end #(
	parameter bit BYTE_WIDE = 1'b0,                 // 1 reads two bytes
	parameter bit USE_BUSY  = 1'b1,                 // 0 waits a fixed time
	parameter int WAIT_CYC  = `AHP_CONV_WAIT_CYC,   // Timed wait length
	parameter int RD_CYC    = `AHP_RD_WAIT_CYC      // Read strobe length
)(
	input  wire logic               sys_clk,         // System clock
	input  wire logic               rst_b,           // Sync reset, low active
	input  wire logic               sample_req,      // Pulse: take one sample
	input  wire logic               ext_start_n,     // Sampling timer strobe, low active
	output logic                    sample_busy,     // Host transaction in progress
	output logic [`AHP_DATA_W-1:0]  result_data,     // FIFO head
	output logic                    result_valid,    // FIFO not empty
	input  wire logic               result_ready,    // User takes head
	output logic                    result_latched_valid, // Standalone latch has data
	output logic [`AHP_DATA_W-1:0]  result_latched,  // Word captured at busy rise
	ahp_if.host                     pins             // Pins to the converter
);
	ahp_pkg::ahp_host_state_t state_reg;   // Sequencer state
	logic [15:0]      cnt_reg;             // Wait and strobe counter
	logic             hi_byte_reg;         // Byte phase: 1 upper
	logic [`AHP_DATA_W-1:0] word_reg;      // Assembled result
	logic             start_n_reg;         // Start pin
	logic             cs_n_reg;            // Select pin
	logic             rd_n_reg;            // Read pin
	logic             busy_d_reg;          // Busy last cycle
	logic             busy_rise;           // Conversion just ended
	logic             fifo_ready;          // FIFO has room
	logic             fifo_valid;          // FIFO has data
	logic [`AHP_DATA_W-1:0] fifo_data;     // FIFO head
	logic             busy_reg;            // Transaction flag
	logic             lat_v_reg;           // Latch holds data
	logic [`AHP_DATA_W-1:0] lat_reg;       // Standalone latch

	assign busy_rise = pins.busy_n && !busy_d_reg;

	// Track busy for the rising edge
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
			busy_d_reg <= 1'b1;
		else
			busy_d_reg <= pins.busy_n;
	end

	// In the word variant only, busy rise clocks the result latch like an output register; bus is otherwise ignored
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			lat_reg   <= '0;
			lat_v_reg <= 1'b0;
		end
		else if (busy_rise && !BYTE_WIDE)
		begin
			lat_reg   <= pins.data_bus;
			lat_v_reg <= 1'b1;
		end
	end

	// Sequencer: start, wait, read one or two times, queue
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			state_reg   <= ahp_pkg::AHP_H_IDLE;
			cnt_reg     <= '0;
			hi_byte_reg <= 1'b1;
			word_reg    <= '0;
			start_n_reg <= 1'b1;
			cs_n_reg    <= 1'b1;
			rd_n_reg    <= 1'b1;
			busy_reg    <= 1'b0;
		end
		else
		begin
			case (state_reg)
				ahp_pkg::AHP_H_IDLE:
				begin
					hi_byte_reg <= 1'b1;
					// The timer strobe is relayed to the start pin one clock late.
					// Otherwise the converter would never see a timer start.
					// The fixed lag keeps the sampling instants on the timer's grid.
					if (!ext_start_n || sample_req)  // Timer or host start
					begin
						busy_reg    <= 1'b1;
						start_n_reg <= 1'b0;
						state_reg   <= ahp_pkg::AHP_H_START;
					end
				end
				ahp_pkg::AHP_H_START:
				begin
					start_n_reg <= 1'b1;
					cnt_reg     <= 16'(WAIT_CYC - 1);
					state_reg   <= ahp_pkg::AHP_H_WAIT;
				end
				ahp_pkg::AHP_H_WAIT:
				begin
					// Strobes stay high here, isolating the bus
					if (cnt_reg != '0)
						cnt_reg <= cnt_reg - 16'h0001;
					if (USE_BUSY ? busy_rise : (cnt_reg <= 16'h0001))
					begin
						cs_n_reg  <= 1'b0;
						rd_n_reg  <= 1'b0;
						cnt_reg   <= 16'(RD_CYC + `AHP_ACCESS_CYC);
						state_reg <= ahp_pkg::AHP_H_READ;
					end
				end
				ahp_pkg::AHP_H_READ:
				begin
					cnt_reg <= cnt_reg - 16'h0001;   // Stretched strobe
					if (cnt_reg == 16'h0001)
					begin
						cs_n_reg <= 1'b1;
						rd_n_reg <= 1'b1;
						if (!BYTE_WIDE)
						begin
							word_reg  <= pins.data_bus;
							state_reg <= ahp_pkg::AHP_H_PUSH;
						end
						else if (hi_byte_reg)
						begin
							word_reg[15:8] <= pins.data_bus[7:0];
							hi_byte_reg    <= 1'b0;
							state_reg      <= ahp_pkg::AHP_H_GAP;
						end
						else
						begin
							word_reg[7:0] <= pins.data_bus[7:0];
							state_reg     <= ahp_pkg::AHP_H_PUSH;
						end
					end
				end
				ahp_pkg::AHP_H_GAP:
				begin
					cs_n_reg  <= 1'b0;               // Second byte read at even address
					rd_n_reg  <= 1'b0;
					cnt_reg   <= 16'(RD_CYC + `AHP_ACCESS_CYC);
					state_reg <= ahp_pkg::AHP_H_READ;
				end
				ahp_pkg::AHP_H_PUSH:
				begin
					if (fifo_ready)                  // Full FIFO stalls the sequencer
					begin
						busy_reg  <= 1'b0;
						state_reg <= ahp_pkg::AHP_H_IDLE;
					end
				end
				default:
					state_reg <= ahp_pkg::AHP_H_IDLE;
			endcase
		end
	end

	ahp_fifo #(.WIDTH(`AHP_DATA_W), .DEPTH(`AHP_FIFO_DEPTH)) u_fifo (
		.sys_clk   (sys_clk),
		.rst_b     (rst_b),
		.in_data   (word_reg),
		.in_valid  (state_reg == ahp_pkg::AHP_H_PUSH),
		.in_ready  (fifo_ready),
		.out_data  (fifo_data),
		.out_valid (fifo_valid),
		.out_ready (result_ready)
	);

	assign pins.conversion_start_n = start_n_reg;
	assign pins.chip_select_n      = cs_n_reg;
	assign pins.read_strobe_n      = rd_n_reg;
	assign pins.byte_addr          = hi_byte_reg;
	assign sample_busy             = busy_reg;
	assign result_data             = fifo_data;
	assign result_valid            = fifo_valid;
	assign result_latched          = lat_reg;
	assign result_latched_valid    = lat_v_reg;
endmodule
`default_nettype wire

// [verification/ahp_pin_props.sv]
// Purpose: Pin timing checks between the word-wide converter and host ends
// Assumes: One clock, sync active-low reset
// Notes:   CONV_CYC must match the converter instance
`include "ahp_map.svh"
`default_nettype none
module ahp_pin_props #(
	parameter int CONV_CYC = 8                              // Conversion length in cycles
)(
	input  wire logic                   sys_clk,            // System clock
	input  wire logic                   rst_b,              // Sync reset, low active
	input  wire logic                   conversion_start_n, // Start strobe
	input  wire logic                   chip_select_n,      // Select
	input  wire logic                   read_strobe_n,      // Read
	input  wire logic                   busy_n,             // Low while converting
	input  wire logic [`AHP_DATA_W-1:0] data_out,           // Converter drive
	input  wire logic                   data_oe             // Converter enable
);
	int low_cnt;                                            // Cycles busy seen low
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	// Length of the running conversion; cleared when busy returns
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b || busy_n)
			low_cnt <= 0;
		else
			low_cnt <= low_cnt + 1;
	end
	AST_BUSY_FALL: assert property ($fell(conversion_start_n) && busy_n |=> !busy_n)
		else $error("busy did not fall after start");
	AST_BUSY_LEN: assert property ($rose(busy_n) |-> low_cnt == CONV_CYC)
		else $error("conversion length wrong");
	AST_BUSY_END: assert property ($fell(busy_n) |-> ##[1:40] busy_n)
		else $error("busy never returned high");
	AST_NO_EARLY_READ: assert property (!busy_n |-> read_strobe_n && chip_select_n)
		else $error("read during conversion");
	AST_READ_AFTER_BUSY: assert property ($rose(busy_n) |=> !chip_select_n && !read_strobe_n)
		else $error("no read after busy rise");
	AST_STROBE_LEN: assert property ($fell(read_strobe_n) |->
		(!read_strobe_n && !chip_select_n) [*3] ##1 (read_strobe_n && chip_select_n))
		else $error("read strobe length wrong");
	AST_OE_LAG: assert property (!chip_select_n && !read_strobe_n |=> data_oe)
		else $error("bus not driven when selected");
	AST_OE_ONLY_SEL: assert property (data_oe |-> !$past(chip_select_n) && !$past(read_strobe_n))
		else $error("bus driven while deselected");
	AST_DATA_STEADY: assert property (data_oe && $past(data_oe) |-> $stable(data_out))
		else $error("data changed while driven");
	AST_START_IDLE: assert property (!conversion_start_n |-> busy_n)
		else $error("start strobe during conversion");
	// Main scenarios reached
	cover property ($rose(busy_n));
	cover property ($fell(read_strobe_n));
	cover property (data_oe);
endmodule
`default_nettype wire

// [verification/adc_host_parallel_interface_bench.sv]
// Purpose: Drives word and byte pairs of converter and host ends and judges results
// Assumes: Short conversion and wait counts for simulation
// Notes:   Inputs change on the falling edge only
`default_nettype none
module adc_host_parallel_interface_bench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int CONV_CYC = 8;    // Shortened conversion
	localparam int WAIT_CYC = 10;   // Shortened timed wait, longer than conversion
	logic               sys_clk = 1'b0;  // System clock
	logic               rst_b;           // Sync reset, low active
	ahp_pkg::ahp_word_t val_w, val_b;    // Analog stand-ins
	logic               req_w, req_b;    // Sample requests
	logic               ext_n_w;         // Timer start, word pair
	logic               busy_w, busy_b;  // Host busy flags
	ahp_pkg::ahp_word_t res_w, res_b;    // FIFO heads
	logic               valid_w, valid_b;// FIFO not empty
	logic               ready_w, ready_b;// FIFO pops
	logic               lat_v;           // Latch holds data
	ahp_pkg::ahp_word_t lat_w;           // Word latched at busy rise
	int                 checks, miscompares; // Report counters
	ahp_if w_if();
	ahp_if b_if();
	ahp_if s_if();
	ahp_adc_end #(.CONV_CYC(CONV_CYC)) u_ahp_adc_end (.sys_clk(sys_clk), .rst_b(rst_b),
		.sample_value(val_w), .pins(w_if.adc));
	// Standalone converter: the bench holds select and read low and pulses the start
	ahp_adc_end #(.CONV_CYC(CONV_CYC)) u_ahp_adc_end_s (.sys_clk(sys_clk), .rst_b(rst_b),
		.sample_value(val_w), .pins(s_if.adc));
	ahp_host_end #(.WAIT_CYC(WAIT_CYC)) u_ahp_host_end (.sys_clk(sys_clk),
		.rst_b(rst_b), .sample_req(req_w), .ext_start_n(ext_n_w), .sample_busy(busy_w), .result_data(res_w),
		.result_valid(valid_w), .result_ready(ready_w), .result_latched_valid(lat_v), .result_latched(lat_w),
		.pins(w_if.host));
	ahp_adc_end #(.CONV_CYC(CONV_CYC), .BYTE_WIDE(1'b1)) u_ahp_adc_end_b (.sys_clk(sys_clk), .rst_b(rst_b),
		.sample_value(val_b), .pins(b_if.adc));
	// Timed-wait byte host; its timer start is not exercised
	ahp_host_end #(.BYTE_WIDE(1'b1), .USE_BUSY(1'b0), .WAIT_CYC(WAIT_CYC)) u_ahp_host_end_b (.sys_clk(sys_clk),
		.rst_b(rst_b), .sample_req(req_b), .ext_start_n(1'b1), .sample_busy(busy_b), .result_data(res_b),
		.result_valid(valid_b), .result_ready(ready_b), .result_latched_valid(), .result_latched(),
		.pins(b_if.host));
	ahp_pin_props #(.CONV_CYC(CONV_CYC)) u_ahp_pin_props (.sys_clk(sys_clk), .rst_b(rst_b),
		.conversion_start_n(w_if.conversion_start_n), .chip_select_n(w_if.chip_select_n),
		.read_strobe_n(w_if.read_strobe_n), .busy_n(w_if.busy_n), .data_out(w_if.data_out), .data_oe(w_if.data_oe));
	// 100 ns period
	always #50 sys_clk = ~sys_clk;
	// Prints counts and verdict, then stops
	task automatic end_sim();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Four-state compare so unknowns never match
	task automatic check(input string what, input ahp_pkg::ahp_word_t exp, input ahp_pkg::ahp_word_t got);
		checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Bounded wait for a result; a hang ends the run
	task automatic wait_valid(input bit byte_side);
		int n;
		n = 0;
		while (((byte_side ? valid_b : valid_w) !== 1'b1) && n < 200)
		begin
			@(negedge sys_clk);
			n++;
		end
		if (n == 200)
		begin
			miscompares++;
			$display("FAIL result wait expected 1 seen 0");
			end_sim();
		end
	endtask
	// One-cycle pop of the word FIFO
	task automatic pop_w();
		ready_w = 1'b1;
		@(negedge sys_clk);
		ready_w = 1'b0;
		@(negedge sys_clk);
	endtask
	// Host-started word conversion with busy handshake
	task automatic t_word(input ahp_pkg::ahp_word_t v);
		val_w = v;
		req_w = 1'b1;
		@(negedge sys_clk);
		req_w = 1'b0;
		wait_valid(1'b0);
		check("word result", v, res_w);
		check("latched word", 16'hFFFF, lat_w); // Bus isolated at busy rise reads the pull-up
		check("latch flag", 16'h0001, {15'h0000, lat_v});
		pop_w();
	endtask
	// Timer-started conversion; only a start pulse is given
	task automatic t_ext(input ahp_pkg::ahp_word_t v);
		val_w = v;
		ext_n_w = 1'b0;
		@(negedge sys_clk);
		ext_n_w = 1'b1;
		wait_valid(1'b0);
		check("timer result", v, res_w);
		pop_w();
	endtask
	// Byte pair: timed wait, two reads, upper byte first
	task automatic t_byte(input ahp_pkg::ahp_word_t v);
		int n, t0, t1, reads;
		logic [1:0] seq;
		logic rd_prev;
		n = 0; t0 = -1; t1 = -1; reads = 0; seq = 2'h0; rd_prev = 1'b1;
		val_b = v;
		req_b = 1'b1;
		@(negedge sys_clk);
		req_b = 1'b0;
		// The start strobe went low at the rising edge just passed and stays low only until the next one
		if (b_if.conversion_start_n === 1'b0)
			t0 = 0;
		// Watch the wire until the word is queued
		while (valid_b !== 1'b1 && n < 200)
		begin
			@(negedge sys_clk);
			n++;
			if (b_if.conversion_start_n === 1'b0 && t0 < 0)
				t0 = n;
			if (b_if.read_strobe_n === 1'b0 && rd_prev === 1'b1)
			begin
				reads++;
				seq = {seq[0], b_if.byte_addr};
				if (t1 < 0)
					t1 = n;
			end
			rd_prev = b_if.read_strobe_n;
		end
		if (n == 200)
		begin
			miscompares++;
			$display("FAIL byte result wait expected 1 seen 0");
			end_sim();
		end
		check("byte reads", 16'h0002, 16'(reads));
		check("byte order", 16'h0002, {14'h0000, seq});
		check("timed wait ok", 16'h0001, {15'h0000, (t0 >= 0) && (t1 - t0 >= WAIT_CYC)});
		check("byte result", v, res_b);
		ready_b = 1'b1;
		@(negedge sys_clk);
		ready_b = 1'b0;
	endtask
	// Standalone: select and read held low, only a start pulse; data must stand at busy rise
	task automatic t_alone(input ahp_pkg::ahp_word_t v);
		int n;
		n = 0;
		val_w = v;
		s_if.conversion_start_n = 1'b0;
		@(negedge sys_clk);
		s_if.conversion_start_n = 1'b1;
		// Count falling edges up to the first one that sees busy high
		while (s_if.busy_n !== 1'b1 && n < 200)
		begin
			@(negedge sys_clk);
			n++;
		end
		if (n == 200)
		begin
			miscompares++;
			$display("FAIL standalone busy expected 1 seen 0");
			end_sim();
		end
		check("standalone length", 16'(CONV_CYC), 16'(n));
		check("standalone data", v, s_if.data_bus);
	endtask
	// Fill the FIFO past full with refused extra requests, then drain
	task automatic t_fill();
		for (int i = 0; i < 9; i++)
		begin
			val_w = 16'hA000 + 16'(i);
			req_w = 1'b1;
			@(negedge sys_clk);
			req_w = 1'b0;
			repeat (2) @(negedge sys_clk);
			req_w = 1'b1; // refused while busy
			@(negedge sys_clk);
			req_w = 1'b0;
			repeat (40) @(negedge sys_clk);
		end
		check("stalled when full", 16'h0001, {15'h0000, busy_w});
		for (int i = 0; i < 9; i++)
		begin
			wait_valid(1'b0);
			check("queued word", 16'hA000 + 16'(i), res_w);
			pop_w();
		end
		check("no extra words", 16'h0000, {15'h0000, valid_w});
	endtask
	// Main sequence
	initial
	begin
		rst_b = 1'b0; req_w = 1'b0; req_b = 1'b0; ext_n_w = 1'b1;
		ready_w = 1'b0; ready_b = 1'b0; val_w = 16'h0000; val_b = 16'h0000;
		checks = 0; miscompares = 0;
		s_if.conversion_start_n = 1'b1;
		s_if.chip_select_n = 1'b0;
		s_if.read_strobe_n = 1'b0;
		s_if.byte_addr = 1'b0;
		repeat (2) @(negedge sys_clk);
		rst_b = 1'b1;
		t_word(16'h8001);
		t_word(16'h7FFE);
		t_ext(16'h5A5A);
		t_byte(16'hC3A5);
		t_alone(16'h1357);
		t_fill();
		end_sim();
	end
endmodule
`default_nettype wire
